// ===== core/flash_prot_pkg.sv
package flash_prot_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] CONFIG_OFS = 8'h00;
    localparam logic [7:0] PROTECT_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] EVT_STATUS_OFS = 8'h0c;
    localparam logic [7:0] EVT_ENABLE_OFS = 8'h10;
    localparam logic [7:0] EVT_CLEAR_OFS = 8'h14;
    localparam logic [7:0] OPTIONS_OFS = 8'h18;

    // flash_config field positions
    localparam int BUF_EMPTY_IRQ_EN_BIT = 7;
    localparam int CMD_DONE_IRQ_EN_BIT = 6;
    localparam int KEY_WRITE_MODE_BIT = 5;
    localparam logic [7:0] CONFIG_RW_MASK = 8'he0;
    localparam logic [7:0] CONFIG_RESET = 8'h00;

    // flash_protection field positions and reset
    localparam int PROTECT_OPEN_BIT = 0;
    localparam int PROTECT_SIZE_LSB = 1;
    localparam logic [7:0] PROTECT_RESET = 8'h00;

    // flash_status field position
    localparam int PROTECT_VIOLATION_BIT = 5;

    // backdoor enable option code
    localparam logic [1:0] BACKDOOR_ENABLED_CODE = 2'h2;
    localparam logic [1:0] OPTIONS_RESET = 2'h0;

    // protection geometry
    localparam logic [7:0] FULL_PROTECT_KB = 8'h80;
    localparam logic [7:0] OPEN_MAX_KB = 8'h7f;
    localparam logic [6:0] ARRAY_SPLIT_SIZE = 7'h3f;
    localparam logic [6:0] NO_PROTECT_SIZE = 7'h7f;

    // command codes relevant to protection
    localparam logic [6:0] CMD_PROGRAM = 7'h20;
    localparam logic [6:0] CMD_BURST_PROGRAM = 7'h25;
    localparam logic [6:0] CMD_SECTOR_ERASE = 7'h40;
    localparam logic [6:0] CMD_MASS_ERASE = 7'h41;

    // event bits
    localparam int EVT_COUNT = 3;
    localparam int EVT_VIOLATION = 0;
    localparam int EVT_MASS_REFUSED = 1;
    localparam int EVT_SHRINK_REFUSED = 2;

    // axi answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // command launch request from the sequencer
    typedef struct packed {
        logic [6:0] code;
        logic [16:0] addr;
    } cmd_req_s;

    // write into the flash block
    typedef struct packed {
        logic [16:0] addr;
        logic [7:0] data;
    } flash_wr_s;

    // protected size in kbytes of a protection byte
    function automatic logic [7:0] prot_size_kb(input logic [7:0] prot);
        if (!prot[PROTECT_OPEN_BIT]) begin
            return FULL_PROTECT_KB;
        end
        return OPEN_MAX_KB - {1'b0, prot[7:1]};
    endfunction : prot_size_kb

endpackage : flash_prot_pkg

// ===== core/prot_range_check.sv
`timescale 1ns/1ps
`default_nettype none
module prot_range_check
    import flash_prot_pkg::*;
(
    // protection setting
    input wire logic [7:0] prot_i,
    // address under test
    input wire logic [16:0] addr_i,
    // answers
    output logic in_range_o,
    output logic any_prot_o
);
    logic open;
    logic [6:0] size_fld;
    logic [5:0] page;

    assign open = prot_i[PROTECT_OPEN_BIT];
    assign size_fld = prot_i[7:1];
    assign page = addr_i[15:10];

    // range reaches top of each array in 1-kbyte pages
    always_comb begin
        if (!open) begin
            in_range_o = 1'b1; // RULE13
        end else if (size_fld < ARRAY_SPLIT_SIZE) begin
            // all of array 0, array 1 above the start page
            in_range_o = !addr_i[16] || (page > size_fld[5:0]); // RULE15
        end else begin
            // array 1 free, array 0 from rising start page
            in_range_o = !addr_i[16] &&
                ({1'b0, page} >= (size_fld - ARRAY_SPLIT_SIZE)); // RULE14 RULE15
        end
    end

    // nothing guarded only for open with all ones
    assign any_prot_o = !(open && (size_fld == NO_PROTECT_SIZE)); // RULE14

endmodule : prot_range_check
`default_nettype wire

// ===== core/event_irq.sv
`timescale 1ns/1ps
`default_nettype none
module event_irq
    import flash_prot_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // event pulses
    input wire logic [EVT_COUNT-1:0] event_i,
    // software access
    input wire logic enable_wr_i,
    input wire logic clear_wr_i,
    input wire logic [EVT_COUNT-1:0] wdata_i,
    // state
    output logic [EVT_COUNT-1:0] status_o,
    output logic [EVT_COUNT-1:0] enable_o,
    output logic irq_o
);
    logic [EVT_COUNT-1:0] status_reg;
    logic [EVT_COUNT-1:0] enable_reg;

    // sticky bits, a new event wins over a clear
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status_reg <= '0;
        end else begin
            status_reg <= (status_reg & ~(clear_wr_i ? wdata_i : '0)) | event_i;
        end
    end

    // enable mask
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            enable_reg <= '0;
        end else if (enable_wr_i) begin
            enable_reg <= wdata_i;
        end
    end

    assign status_o = status_reg;
    assign enable_o = enable_reg;
    assign irq_o = |(status_reg & enable_reg);

endmodule : event_irq
`default_nettype wire

// ===== core/flash_protect_config.sv
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RULE1] only key-write mode and the two interrupt enables of the config register hold; others read zero.
// [RULE2] key-write mode is writable only while the backdoor option is enabled.
// [RULE3] the backdoor option enables key access only for code 10.
// [RULE4] with key-write mode (bit 5) clear, a flash-block write starts a command sequence.
// [RULE5] with key-write mode set, a flash-block write is a backdoor key, not a command start.
// [RULE6] flash array reads keep being served while key-write mode is set.
// [RULE7] a protection write is kept only if it does not shrink the protected area.
// [RULE8] the protection register is loaded from the nonvolatile protection byte at reset.
// [RULE9] software changes the reset protection by unprotecting, erasing and reprogramming its sector.
// [RULE10] program or erase inside the protected range is blocked and sets the violation flag.
// [RULE11] the violation flag clears on a written one and blocks launches and sequence starts.
// [RULE12] mass erase is refused while anything is protected.
// [RULE13] with protect_open (bit 0) zero all 128 kbytes are protected.
// [RULE14] with protect_open set the size is 127 kbytes minus bits 7:1, 0x7f guarding none.
// [RULE15] the range reaches the top of each array, split at field value 0x3f.
// [RULE16] the range check is done before a launch so a blocked one never reaches the array.
module flash_protect_config
    import flash_prot_pkg::*;
(
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RST_B_I,
    // axi4-lite write address and data
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [7:0] AWADDR_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    // axi4-lite write response
    output logic BVALID_O,
    input wire logic BREADY_I,
    output logic [1:0] BRESP_O,
    // axi4-lite read
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    input wire logic [7:0] ARADDR_I,
    output logic RVALID_O,
    input wire logic RREADY_I,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O,
    // nonvolatile bytes sampled after reset
    input wire logic [7:0] NV_PROTECT_BYTE_I,
    input wire logic [1:0] BACKDOOR_ENABLE_OPT_I,
    // cpu writes and reads to the flash block
    input wire logic FLASH_WR_VALID_I,
    input wire flash_wr_s FLASH_WR_I,
    input wire logic FLASH_RD_REQ_I,
    output logic FLASH_RD_EN_O,
    // toward the command sequencer
    output logic CMD_SEQ_START_O,
    output logic KEY_WR_O,
    output flash_wr_s FLASH_WR_O,
    input wire logic CMD_REQ_VALID_I,
    input wire cmd_req_s CMD_REQ_I,
    output logic CMD_LAUNCH_O,
    output cmd_req_s CMD_LAUNCH_REQ_O,
    output logic CMD_BLOCKED_O,
    // configuration outputs
    output logic KEY_WRITE_MODE_O,
    output logic BUFFER_EMPTY_IRQ_EN_O,
    output logic CMD_DONE_IRQ_EN_O,
    output logic PROTECT_VIOLATION_FLAG_O,
    output logic IRQ_O
);
    logic [7:0] config_reg;
    logic [7:0] protect_reg;
    logic [1:0] options_reg;
    logic loaded_reg;
    logic violation_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic seq_start_reg;
    logic key_wr_reg;
    flash_wr_s flash_wr_reg;
    logic launch_reg;
    logic blocked_reg;
    cmd_req_s launch_req_reg;
    logic do_write;
    logic wr_lane0;
    logic [7:0] wbyte;
    logic key_allowed;
    logic in_range;
    logic any_prot;
    logic is_guarded_cmd;
    logic cmd_refused;
    logic cmd_violation;
    logic shrink_refused;
    logic [EVT_COUNT-1:0] evt_status;
    logic [EVT_COUNT-1:0] evt_enable;
    logic [EVT_COUNT-1:0] events;

    // address decode shared by both channels
    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            CONFIG_OFS, PROTECT_OFS, STATUS_OFS, EVT_STATUS_OFS,
            EVT_ENABLE_OFS, EVT_CLEAR_OFS, OPTIONS_OFS: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : is_mapped

    // write channel capture, either order
    assign AWREADY_O = !aw_held_reg && !bvalid_reg;
    assign WREADY_O = !w_held_reg && !bvalid_reg;
    assign do_write = aw_held_reg && w_held_reg;
    assign wr_lane0 = do_write && wstrb_reg[0];
    assign wbyte = wdata_reg[7:0];

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
        end else begin
            if (AWVALID_I && AWREADY_O) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= {AWADDR_I[7:2], 2'h0};
            end
            if (WVALID_I && WREADY_O) begin
                w_held_reg <= 1'b1;
                wdata_reg <= WDATA_I;
                wstrb_reg <= WSTRB_I;
            end
        end
    end

    // write response one cycle after both halves are held
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= is_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
        end else if (BREADY_I) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign BVALID_O = bvalid_reg;
    assign BRESP_O = bresp_reg;

    // read channel, data one cycle after the address
    assign ARREADY_O = !rvalid_reg;

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else if (ARVALID_I && ARREADY_O) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= is_mapped({ARADDR_I[7:2], 2'h0}) ? RESP_OKAY : RESP_SLVERR;
            case ({ARADDR_I[7:2], 2'h0})
                CONFIG_OFS: rdata_reg <= {24'h000000, config_reg};
                PROTECT_OFS: rdata_reg <= {24'h000000, protect_reg};
                STATUS_OFS: rdata_reg <= {26'h0000000, violation_reg, 5'h00};
                EVT_STATUS_OFS: rdata_reg <= {29'h00000000, evt_status};
                EVT_ENABLE_OFS: rdata_reg <= {29'h00000000, evt_enable};
                OPTIONS_OFS: rdata_reg <= {30'h00000000, options_reg};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end else if (RREADY_I) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign RVALID_O = rvalid_reg;
    assign RDATA_O = rdata_reg;
    assign RRESP_O = rresp_reg;

    // backdoor option decode
    assign key_allowed = (options_reg == BACKDOOR_ENABLED_CODE); // RULE3

    // configuration register
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            config_reg <= CONFIG_RESET;
        end else if (wr_lane0 && awaddr_reg == CONFIG_OFS) begin
            config_reg[BUF_EMPTY_IRQ_EN_BIT] <= wbyte[BUF_EMPTY_IRQ_EN_BIT]; // RULE1
            config_reg[CMD_DONE_IRQ_EN_BIT] <= wbyte[CMD_DONE_IRQ_EN_BIT]; // RULE1
            if (key_allowed) begin
                config_reg[KEY_WRITE_MODE_BIT] <= wbyte[KEY_WRITE_MODE_BIT]; // RULE2
            end
        end
    end

    // one-shot load of nonvolatile bytes after reset release
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            loaded_reg <= 1'b0;
            options_reg <= OPTIONS_RESET;
        end else if (!loaded_reg) begin
            loaded_reg <= 1'b1;
            options_reg <= BACKDOOR_ENABLE_OPT_I;
        end
    end

    // protection register, may only grow
    assign shrink_refused = wr_lane0 && loaded_reg && awaddr_reg == PROTECT_OFS &&
        (prot_size_kb(wbyte) < prot_size_kb(protect_reg));

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            protect_reg <= PROTECT_RESET;
        end else if (!loaded_reg) begin
            protect_reg <= NV_PROTECT_BYTE_I; // RULE8
        end else if (wr_lane0 && awaddr_reg == PROTECT_OFS && !shrink_refused) begin
            protect_reg <= wbyte; // RULE7
        end
    end

    // range check on the pending launch address
    prot_range_check u_range (
        .prot_i(protect_reg),
        .addr_i(CMD_REQ_I.addr),
        .in_range_o(in_range),
        .any_prot_o(any_prot)
    );

    assign is_guarded_cmd = CMD_REQ_I.code == CMD_PROGRAM ||
        CMD_REQ_I.code == CMD_BURST_PROGRAM || CMD_REQ_I.code == CMD_SECTOR_ERASE;
    assign cmd_violation = CMD_REQ_VALID_I && loaded_reg && !violation_reg &&
        ((is_guarded_cmd && in_range) || // RULE10 RULE16
         (CMD_REQ_I.code == CMD_MASS_ERASE && any_prot)); // RULE12
    assign cmd_refused = CMD_REQ_VALID_I && (violation_reg || !loaded_reg || cmd_violation);

    // violation flag, a new violation wins over a written one
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            violation_reg <= 1'b0;
        end else if (cmd_violation) begin
            violation_reg <= 1'b1; // RULE10
        end else if (wr_lane0 && awaddr_reg == STATUS_OFS && wbyte[PROTECT_VIOLATION_BIT]) begin
            violation_reg <= 1'b0; // RULE11
        end
    end

    // launch gate toward the array
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            launch_reg <= 1'b0;
            blocked_reg <= 1'b0;
            launch_req_reg <= '0;
        end else begin
            launch_reg <= CMD_REQ_VALID_I && !cmd_refused; // RULE11 RULE16
            blocked_reg <= cmd_refused;
            if (CMD_REQ_VALID_I) begin
                launch_req_reg <= CMD_REQ_I;
            end
        end
    end

    // flash block writes: key capture or sequence start
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            seq_start_reg <= 1'b0;
            key_wr_reg <= 1'b0;
            flash_wr_reg <= '0;
        end else begin
            key_wr_reg <= FLASH_WR_VALID_I && config_reg[KEY_WRITE_MODE_BIT]; // RULE5
            seq_start_reg <= FLASH_WR_VALID_I && !config_reg[KEY_WRITE_MODE_BIT] &&
                !violation_reg; // RULE4 RULE11
            if (FLASH_WR_VALID_I) begin
                flash_wr_reg <= FLASH_WR_I;
            end
        end
    end

    // reads pass regardless of key-write mode
    assign FLASH_RD_EN_O = FLASH_RD_REQ_I; // RULE6

    // events and interrupt
    assign events = {shrink_refused,
        cmd_violation && CMD_REQ_I.code == CMD_MASS_ERASE, cmd_violation};

    event_irq u_irq (
        .clk_i(CORE_CLK_I),
        .rst_b_i(RST_B_I),
        .event_i(events),
        .enable_wr_i(wr_lane0 && awaddr_reg == EVT_ENABLE_OFS),
        .clear_wr_i(wr_lane0 && awaddr_reg == EVT_CLEAR_OFS),
        .wdata_i(wbyte[EVT_COUNT-1:0]),
        .status_o(evt_status),
        .enable_o(evt_enable),
        .irq_o(IRQ_O)
    );

    // outputs
    assign CMD_SEQ_START_O = seq_start_reg;
    assign KEY_WR_O = key_wr_reg;
    assign FLASH_WR_O = flash_wr_reg;
    assign CMD_LAUNCH_O = launch_reg;
    assign CMD_LAUNCH_REQ_O = launch_req_reg;
    assign CMD_BLOCKED_O = blocked_reg;
    assign KEY_WRITE_MODE_O = config_reg[KEY_WRITE_MODE_BIT];
    assign BUFFER_EMPTY_IRQ_EN_O = config_reg[BUF_EMPTY_IRQ_EN_BIT];
    assign CMD_DONE_IRQ_EN_O = config_reg[CMD_DONE_IRQ_EN_BIT];
    assign PROTECT_VIOLATION_FLAG_O = violation_reg;

endmodule : flash_protect_config
`default_nettype wire

// ===== verif/flash_protect_config_sva.sv
`timescale 1ns/1ps
`default_nettype none
module flash_protect_config_chk
    import flash_prot_pkg::*;
(
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RST_B_I,
    // flash block side
    input wire logic FLASH_WR_VALID_I,
    input wire logic FLASH_RD_REQ_I,
    input wire logic FLASH_RD_EN_O,
    input wire logic CMD_SEQ_START_O,
    input wire logic KEY_WR_O,
    input wire logic KEY_WRITE_MODE_O,
    input wire logic PROTECT_VIOLATION_FLAG_O,
    // command launch side
    input wire logic CMD_REQ_VALID_I,
    input wire cmd_req_s CMD_REQ_I,
    input wire logic CMD_LAUNCH_O,
    input wire cmd_req_s CMD_LAUNCH_REQ_O,
    input wire logic CMD_BLOCKED_O
);
    // one clock domain for all checks
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_B_I);

    key_write_a: assert property (
        FLASH_WR_VALID_I && KEY_WRITE_MODE_O |=> KEY_WR_O && !CMD_SEQ_START_O)
        else $error("key mode write not taken as key");
    seq_start_a: assert property (
        FLASH_WR_VALID_I && !KEY_WRITE_MODE_O && !PROTECT_VIOLATION_FLAG_O
        |=> CMD_SEQ_START_O && !KEY_WR_O) else $error("flash write did not start sequence");
    viol_no_start_a: assert property (
        FLASH_WR_VALID_I && PROTECT_VIOLATION_FLAG_O |=> !CMD_SEQ_START_O)
        else $error("sequence started while violation flag set");
    read_served_a: assert property (
        FLASH_RD_EN_O == FLASH_RD_REQ_I) else $error("flash read not passed");
    one_answer_a: assert property (
        CMD_REQ_VALID_I |=> CMD_LAUNCH_O != CMD_BLOCKED_O)
        else $error("launch request without single answer");
    no_stray_answer_a: assert property (
        CMD_LAUNCH_O || CMD_BLOCKED_O |-> $past(CMD_REQ_VALID_I))
        else $error("launch answer without request");
    launch_flag_clear_a: assert property (
        CMD_LAUNCH_O |-> !$past(PROTECT_VIOLATION_FLAG_O) && CMD_LAUNCH_REQ_O == $past(CMD_REQ_I))
        else $error("launch while flag set or wrong request copy");
    flag_cause_a: assert property (
        $rose(PROTECT_VIOLATION_FLAG_O) |-> $past(CMD_REQ_VALID_I) && CMD_BLOCKED_O)
        else $error("violation flag set without blocked command");
endmodule : flash_protect_config_chk

bind flash_protect_config flash_protect_config_chk chk (
    .CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I), .FLASH_WR_VALID_I(FLASH_WR_VALID_I),
    .FLASH_RD_REQ_I(FLASH_RD_REQ_I), .FLASH_RD_EN_O(FLASH_RD_EN_O),
    .CMD_SEQ_START_O(CMD_SEQ_START_O), .KEY_WR_O(KEY_WR_O), .KEY_WRITE_MODE_O(KEY_WRITE_MODE_O),
    .PROTECT_VIOLATION_FLAG_O(PROTECT_VIOLATION_FLAG_O), .CMD_REQ_VALID_I(CMD_REQ_VALID_I),
    .CMD_REQ_I(CMD_REQ_I), .CMD_LAUNCH_O(CMD_LAUNCH_O), .CMD_LAUNCH_REQ_O(CMD_LAUNCH_REQ_O),
    .CMD_BLOCKED_O(CMD_BLOCKED_O));
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import flash_prot_pkg::*;
;
    typedef struct packed {logic [7:0] nv; logic [6:0] code; logic [16:0] addr; logic go;} row_s;
    // protection byte, command, address, launch expected
    localparam row_s ROWS [17] = '{
        '{8'h00, CMD_PROGRAM, 17'h00000, 1'h0}, '{8'h00, CMD_PROGRAM, 17'h1ffff, 1'h0},
        '{8'h01, CMD_PROGRAM, 17'h103ff, 1'h1}, '{8'h01, CMD_PROGRAM, 17'h10400, 1'h0},
        '{8'h7d, CMD_PROGRAM, 17'h1fbff, 1'h1}, '{8'h7d, CMD_PROGRAM, 17'h1fc00, 1'h0},
        '{8'h7d, CMD_SECTOR_ERASE, 17'h0ffff, 1'h0}, '{8'h7f, CMD_SECTOR_ERASE, 17'h10000, 1'h1},
        '{8'h7f, CMD_BURST_PROGRAM, 17'h0ffff, 1'h0}, '{8'h81, CMD_PROGRAM, 17'h003ff, 1'h1},
        '{8'h81, CMD_PROGRAM, 17'h00400, 1'h0}, '{8'hff, CMD_PROGRAM, 17'h0ffff, 1'h1},
        '{8'hff, CMD_MASS_ERASE, 17'h00000, 1'h1}, '{8'hfd, CMD_MASS_ERASE, 17'h00000, 1'h0},
        '{8'hfd, CMD_PROGRAM, 17'h0fbff, 1'h1}, '{8'hfd, CMD_PROGRAM, 17'h0fc00, 1'h0},
        '{8'h00, 7'h05, 17'h00000, 1'h1}};
    logic CORE_CLK_I, RST_B_I, AWVALID_I, AWREADY_O, WVALID_I, WREADY_O, BVALID_O, BREADY_I;
    logic ARVALID_I, ARREADY_O, RVALID_O, RREADY_I, FLASH_WR_VALID_I, FLASH_RD_REQ_I, IRQ_O;
    logic FLASH_RD_EN_O, CMD_SEQ_START_O, KEY_WR_O, CMD_REQ_VALID_I, CMD_LAUNCH_O, CMD_BLOCKED_O;
    logic KEY_WRITE_MODE_O, BUFFER_EMPTY_IRQ_EN_O, CMD_DONE_IRQ_EN_O, PROTECT_VIOLATION_FLAG_O;
    logic [7:0] AWADDR_I, ARADDR_I, NV_PROTECT_BYTE_I;
    logic [31:0] WDATA_I, RDATA_O, rd;
    logic [3:0] WSTRB_I;
    logic [1:0] BRESP_O, RRESP_O, BACKDOOR_ENABLE_OPT_I, resp;
    flash_wr_s FLASH_WR_I, FLASH_WR_O;
    cmd_req_s CMD_REQ_I, CMD_LAUNCH_REQ_O;
    int n_fail = 0;
    int n_checks = 0;

    flash_protect_config uut (.CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I),
        .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .AWADDR_I(AWADDR_I), .WVALID_I(WVALID_I),
        .WREADY_O(WREADY_O), .WDATA_I(WDATA_I), .WSTRB_I(WSTRB_I), .BVALID_O(BVALID_O),
        .BREADY_I(BREADY_I), .BRESP_O(BRESP_O), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O),
        .ARADDR_I(ARADDR_I), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I), .RDATA_O(RDATA_O),
        .RRESP_O(RRESP_O), .NV_PROTECT_BYTE_I(NV_PROTECT_BYTE_I),
        .BACKDOOR_ENABLE_OPT_I(BACKDOOR_ENABLE_OPT_I), .FLASH_WR_VALID_I(FLASH_WR_VALID_I),
        .FLASH_WR_I(FLASH_WR_I), .FLASH_RD_REQ_I(FLASH_RD_REQ_I), .FLASH_RD_EN_O(FLASH_RD_EN_O),
        .CMD_SEQ_START_O(CMD_SEQ_START_O), .KEY_WR_O(KEY_WR_O), .FLASH_WR_O(FLASH_WR_O),
        .CMD_REQ_VALID_I(CMD_REQ_VALID_I), .CMD_REQ_I(CMD_REQ_I), .CMD_LAUNCH_O(CMD_LAUNCH_O),
        .CMD_LAUNCH_REQ_O(CMD_LAUNCH_REQ_O), .CMD_BLOCKED_O(CMD_BLOCKED_O),
        .KEY_WRITE_MODE_O(KEY_WRITE_MODE_O), .BUFFER_EMPTY_IRQ_EN_O(BUFFER_EMPTY_IRQ_EN_O),
        .CMD_DONE_IRQ_EN_O(CMD_DONE_IRQ_EN_O), .PROTECT_VIOLATION_FLAG_O(PROTECT_VIOLATION_FLAG_O),
        .IRQ_O(IRQ_O));

    // 250 mhz clock
    initial begin
        CORE_CLK_I = 1'b0;
        forever #2 CORE_CLK_I = ~CORE_CLK_I;
    end

    task automatic test_done;
        if (n_fail == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // reset with given nonvolatile bytes
    task automatic do_reset(input logic [7:0] nv, input logic [1:0] opt);
        @(posedge CORE_CLK_I);
        RST_B_I <= 1'b0;
        NV_PROTECT_BYTE_I <= nv;
        BACKDOOR_ENABLE_OPT_I <= opt;
        repeat (6) @(posedge CORE_CLK_I);
        RST_B_I <= 1'b1;
        repeat (2) @(posedge CORE_CLK_I);
    endtask : do_reset

    // axi4-lite write
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, bv;
        @(posedge CORE_CLK_I);
        AWVALID_I <= 1'b1; AWADDR_I <= a; WVALID_I <= 1'b1; WDATA_I <= d; BREADY_I <= 1'b1;
        do begin
            @(negedge CORE_CLK_I);
            aw = AWVALID_I & AWREADY_O;
            w = WVALID_I & WREADY_O;
            bv = BVALID_O;
            resp = BRESP_O;
            @(posedge CORE_CLK_I);
            if (aw) AWVALID_I <= 1'b0;
            if (w) WVALID_I <= 1'b0;
            if (bv) BREADY_I <= 1'b0;
        end while (!bv);
    endtask : bus_wr

    // axi4-lite read into rd and resp
    task automatic bus_rd(input logic [7:0] a);
        logic ar, rv;
        @(posedge CORE_CLK_I);
        ARVALID_I <= 1'b1; ARADDR_I <= a; RREADY_I <= 1'b1;
        do begin
            @(negedge CORE_CLK_I);
            ar = ARVALID_I & ARREADY_O;
            rv = RVALID_O;
            rd = RDATA_O;
            resp = RRESP_O;
            @(posedge CORE_CLK_I);
            if (ar) ARVALID_I <= 1'b0;
            if (rv) RREADY_I <= 1'b0;
        end while (!rv);
    endtask : bus_rd

    // one flash block write and its classification pulses
    task automatic fwr(input logic key, input logic start);
        @(posedge CORE_CLK_I);
        FLASH_WR_VALID_I <= 1'b1;
        FLASH_WR_I <= '{17'h12345, 8'h5a};
        @(posedge CORE_CLK_I);
        FLASH_WR_VALID_I <= 1'b0;
        #1;
        chk(KEY_WR_O, key);
        chk(CMD_SEQ_START_O, start);
        chk(FLASH_WR_O, {17'h12345, 8'h5a});
    endtask : fwr

    // one launch request and its answer
    task automatic cmd(input logic [6:0] code, input logic [16:0] addr, input logic go);
        @(posedge CORE_CLK_I);
        CMD_REQ_VALID_I <= 1'b1;
        CMD_REQ_I <= '{code, addr};
        @(posedge CORE_CLK_I);
        CMD_REQ_VALID_I <= 1'b0;
        #1;
        chk(CMD_LAUNCH_O, go);
        chk(CMD_BLOCKED_O, !go);
    endtask : cmd

    // watchdog
    initial begin
        #200000;
        n_fail++;
        test_done;
    end

    // main sequence
    initial begin
        {AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I} = 5'h00;
        {FLASH_WR_VALID_I, FLASH_RD_REQ_I, CMD_REQ_VALID_I} = 3'h0;
        AWADDR_I = 8'h00; ARADDR_I = 8'h00; WDATA_I = 32'h0; WSTRB_I = 4'h1;
        FLASH_WR_I = '0; CMD_REQ_I = '0; RST_B_I = 1'b0;
        for (int i = 0; i < 17; i++) begin
            do_reset(ROWS[i].nv, 2'h0);
            bus_rd(PROTECT_OFS);
            chk(rd, {24'h0, ROWS[i].nv});
            cmd(ROWS[i].code, ROWS[i].addr, ROWS[i].go);
            if (ROWS[i].code != CMD_MASS_ERASE) chk(PROTECT_VIOLATION_FLAG_O, !ROWS[i].go);
        end
        // backdoor option gates key mode
        for (int o = 0; o < 4; o++) begin
            do_reset(8'h00, o[1:0]);
            bus_rd(CONFIG_OFS);
            chk(rd, 32'h0);
            bus_wr(CONFIG_OFS, 32'hffff_ffff);
            bus_rd(CONFIG_OFS);
            chk(rd, (o == 2) ? 32'he0 : 32'hc0);
            chk(KEY_WRITE_MODE_O, o == 2);
            chk({BUFFER_EMPTY_IRQ_EN_O, CMD_DONE_IRQ_EN_O}, 32'h3);
        end
        // key mode steers flash writes, reads still served
        do_reset(8'h00, 2'h2);
        bus_wr(CONFIG_OFS, 32'h20);
        fwr(1'b1, 1'b0);
        @(posedge CORE_CLK_I);
        FLASH_RD_REQ_I <= 1'b1;
        #1;
        chk(FLASH_RD_EN_O, 1'b1);
        bus_wr(CONFIG_OFS, 32'h0);
        fwr(1'b0, 1'b1);
        // protection may only grow, shrinking writes refused and flagged
        do_reset(8'hfd, 2'h0);
        bus_wr(PROTECT_OFS, 32'hff);
        bus_rd(PROTECT_OFS);
        chk(rd, 32'hfd);
        bus_wr(PROTECT_OFS, 32'h81);
        bus_rd(PROTECT_OFS);
        chk(rd, 32'h81);
        bus_wr(PROTECT_OFS, 32'h00);
        bus_wr(PROTECT_OFS, 32'h01);
        bus_rd(PROTECT_OFS);
        chk(rd, 32'h00);
        bus_rd(EVT_STATUS_OFS);
        chk(rd, 32'h4);
        // violation flag blocks, clears on one, raises interrupt
        do_reset(8'h00, 2'h0);
        cmd(CMD_PROGRAM, 17'h00010, 1'b0);
        fwr(1'b0, 1'b0);
        cmd(7'h05, 17'h00000, 1'b0);
        bus_rd(STATUS_OFS);
        chk(rd, 32'h20);
        bus_wr(STATUS_OFS, 32'h0);
        chk(PROTECT_VIOLATION_FLAG_O, 1'b1);
        bus_rd(EVT_STATUS_OFS);
        chk(rd, 32'h1);
        chk(IRQ_O, 1'b0);
        bus_wr(EVT_ENABLE_OFS, 32'h1);
        chk(IRQ_O, 1'b1);
        bus_wr(STATUS_OFS, 32'h20);
        chk(PROTECT_VIOLATION_FLAG_O, 1'b0);
        bus_wr(EVT_CLEAR_OFS, 32'h1);
        chk(IRQ_O, 1'b0);
        cmd(7'h05, 17'h00000, 1'b1);
        // unmapped address answers with an error
        bus_rd(8'h1c);
        chk(resp, RESP_SLVERR);
        chk(rd, 32'h0);
        bus_wr(8'h1c, 32'h1);
        chk(resp, RESP_SLVERR);
        test_done;
    end
endmodule : testbench
`default_nettype wire
